// ==== rtl/relay_threshold_controller.sv ====
`timescale 1ns/1ps
// Functional notes
// - First threshold per channel, signed, -999 to 9999, centre of its band.
// - Second threshold per channel, -999 to 9999, used only in window modes.
// - Band half-width 0 to 999; full band is twice the setting.
// - Output may change only when input lies outside the threshold band.
// - Inactive mode keeps output off unless fault reaction forces it on.
// - One-on mode: on above threshold plus band, off below threshold minus band.
// - One-off mode: off above threshold plus band, on below minus band.
// - Inside-window: on between lower plus band and higher minus band.
// - Outside-window: on above higher plus band or below lower minus band.
// - Higher and lower thresholds found by comparison, any order allowed.
// - Serial mode drives output from serial commands, ignoring measurement.
// - Indicator LED lit whenever the channel relay is closed.
// - Serially set output states are not retained across power loss.
// - Turn on only after dwell beyond border for turn-on delay, 0 to 99.9.
// - Turn off only after dwell beyond border for turn-off delay, 0 to 99.9.
// - Output unchanged if input returns before the delay elapses.
// - Delays counted in seconds or minutes, selectable per channel.
// - On fault apply reaction: hold state, force on, or force off.
// - Threshold modes treat out-of-range measurement as a fault.
// - Serial mode treats frame gap longer than timeout as a fault.
// - Force-on reaction turns output on even in inactive mode.
// - Independent settings per channel; LED driven on every channel, relay only where fitted.
// - Frame timeout 0 to 99 seconds; zero disables the supervision.
// - With both delays zero the output follows at once on a border crossing.
module relay_threshold_controller
	import rtc_pkg::*;
#(
	parameter int CHANNELS = 3,
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic                              clk,
	input  wire logic                              rst,
	// Measurement: live value, detected peak and their range flags.
	input  wire logic signed [VALUE_W-1:0]         measuredValue,
	input  wire logic                              measuredOutOfRange,
	input  wire logic signed [VALUE_W-1:0]         peakValue,
	input  wire logic                              peakOutOfRange,
	// Serial side: pulse on each good frame, per-channel commanded state.
	input  wire logic                              frameReceived,
	input  wire logic                              serialWrite,
	input  wire logic [CHANNELS-1:0]               serialState,
	input  wire logic [GAP_W-1:0]                  frame_gap_timeout,
	// Per-channel settings, packed channel 0 in the low slice.
	input  wire logic [CHANNELS*VALUE_W-1:0]       first_threshold,
	input  wire logic [CHANNELS*VALUE_W-1:0]       second_threshold,
	input  wire logic [CHANNELS*VALUE_W-1:0]       band_half_width,
	input  wire logic [CHANNELS*3-1:0]             channelMode,
	input  wire logic [CHANNELS*DELAY_W-1:0]       turn_on_delay,
	input  wire logic [CHANNELS*DELAY_W-1:0]       turn_off_delay,
	input  wire logic [CHANNELS-1:0]               unitMinutes,
	input  wire logic [CHANNELS*2-1:0]             fault_response,
	input  wire logic [CHANNELS-1:0]               usePeak,
	input  wire logic [CHANNELS-1:0]               relayFitted,
	// Outputs to relay drivers and indicator LEDs, and the serial fault flag.
	output logic      [CHANNELS-1:0]               relayDrive,
	output logic      [CHANNELS-1:0]               indicatorLed,
	output logic                                   serialFault
);
	logic        tick;
	logic [COUNT_W-1:0] gapCountQ;
	logic        serialFaultQ;

	// Limits a setting to its documented range so a bad value cannot widen a band.
	function automatic logic signed [VALUE_W:0] clampThresh(input logic signed [VALUE_W-1:0] v);
		if (v < THRESH_MIN) begin
			return (VALUE_W+1)'(THRESH_MIN);
		end else if (v > THRESH_MAX) begin
			return (VALUE_W+1)'(THRESH_MAX);
		end
		return (VALUE_W+1)'(v);
	endfunction

	function automatic logic [DELAY_W-1:0] clampDelay(input logic [DELAY_W-1:0] v);
		return (v > DELAY_MAX) ? DELAY_MAX : v;
	endfunction

	rtc_tick_divider #(
		.CYCLES(TICK_DIV)
	) uTick (
		.clk (clk),
		.rst (rst),
		.tick(tick)
	);

	// Frame gap supervision in tenths of a second; zero timeout disables it.
	always_ff @(posedge clk) begin
		if (rst) begin
			gapCountQ    <= '0;
			serialFaultQ <= 1'b0;
		end else if (frameReceived || frame_gap_timeout == '0) begin
			gapCountQ    <= '0;
			serialFaultQ <= 1'b0;
		end else if (tick) begin
			if (gapCountQ > COUNT_W'(((frame_gap_timeout > GAP_MAX) ? GAP_MAX : frame_gap_timeout))
					* TENTHS_PER_SEC) begin
				serialFaultQ <= 1'b1;
			end else begin
				gapCountQ <= gapCountQ + 20'h0_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			serialFault <= 1'b0;
		end else begin
			serialFault <= serialFaultQ;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : gChan
			logic signed [VALUE_W:0]   thrA;
			logic signed [VALUE_W:0]   thrB;
			logic signed [VALUE_W:0]   thrHi;
			logic signed [VALUE_W:0]   thrLo;
			logic signed [VALUE_W:0]   band;
			logic signed [VALUE_W+1:0] value;
			logic                      outOfRange;
			rtc_mode_type              mode;
			rtc_fault_type             faultSel;
			logic                      wantValid;
			logic                      wantOn;
			logic                      fault;
			logic [COUNT_W-1:0]        needTicks;
			logic [COUNT_W-1:0]        dwellQ;
			logic                      stateQ;
			logic                      serialQ;
			logic                      relayQ;
			logic                      ledQ;

			assign thrA  = clampThresh(first_threshold[ch*VALUE_W +: VALUE_W]);
			assign thrB  = clampThresh(second_threshold[ch*VALUE_W +: VALUE_W]);
			assign band  = (VALUE_W+1)'((band_half_width[ch*VALUE_W +: VALUE_W] > BAND_MAX)
				? BAND_MAX : band_half_width[ch*VALUE_W +: VALUE_W]);
			assign thrHi = (thrA > thrB) ? thrA : thrB;
			assign thrLo = (thrA > thrB) ? thrB : thrA;
			assign value = usePeak[ch] ? (VALUE_W+2)'(peakValue) : (VALUE_W+2)'(measuredValue);
			assign outOfRange = usePeak[ch] ? peakOutOfRange : measuredOutOfRange;
			assign mode     = rtc_mode_type'(channelMode[ch*3 +: 3]);
			assign faultSel = rtc_fault_type'(fault_response[ch*2 +: 2]);

			// Desired state exists only outside the bands; inside, wantValid drops.
			always_comb begin
				wantValid = 1'b0;
				wantOn    = 1'b0;
				unique case (mode)
					MODE_ONE_ON, MODE_ONE_OFF: begin
						if (value > thrA + band) begin
							wantValid = 1'b1;
							wantOn    = (mode == MODE_ONE_ON);
						end else if (value < thrA - band) begin
							wantValid = 1'b1;
							wantOn    = (mode == MODE_ONE_OFF);
						end
					end
					MODE_INSIDE, MODE_OUTSIDE: begin
						if (value > thrLo + band && value < thrHi - band) begin
							wantValid = 1'b1;
							wantOn    = (mode == MODE_INSIDE);
						end else if (value > thrHi + band || value < thrLo - band) begin
							wantValid = 1'b1;
							wantOn    = (mode == MODE_OUTSIDE);
						end
					end
					default: begin
						wantValid = 1'b0;
						wantOn    = 1'b0;
					end
				endcase
			end

			always_comb begin
				unique case (mode)
					MODE_SERIAL:   fault = serialFaultQ;
					MODE_INACTIVE: fault = 1'b1;
					default:       fault = outOfRange;
				endcase
			end

			// Turn-on or turn-off delay in tick units, scaled by the unit selection.
			assign needTicks = COUNT_W'(clampDelay(wantOn
				? turn_on_delay[ch*DELAY_W +: DELAY_W]
				: turn_off_delay[ch*DELAY_W +: DELAY_W]))
				* (unitMinutes[ch] ? TENTHS_PER_MIN_STEP
				                   : TENTHS_PER_SEC_STEP);

			// Dwell counter restarts whenever the input is back inside a band.
			always_ff @(posedge clk) begin
				if (rst || !wantValid || wantOn == stateQ) begin
					dwellQ <= '0;
				end else if (tick && dwellQ < needTicks) begin
					dwellQ <= dwellQ + 20'h0_0001;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					stateQ <= RESET_OUT;
				end else if (wantValid && wantOn != stateQ && dwellQ >= needTicks) begin
					stateQ <= wantOn;
				end
			end

			// Serial state is volatile: reset clears it, nothing keeps it.
			always_ff @(posedge clk) begin
				if (rst) begin
					serialQ <= RESET_OUT;
				end else if (serialWrite) begin
					serialQ <= serialState[ch];
				end
			end

			// Final selection with fault reaction; inactive only honours force-on.
			logic relayNext;
			always_comb begin
				relayNext = (mode == MODE_SERIAL) ? serialQ : stateQ;
				if (mode == MODE_INACTIVE) begin
					relayNext = (faultSel == FAULT_ON);
				end else if (fault) begin
					unique case (faultSel)
						FAULT_ON:  relayNext = 1'b1;
						FAULT_OFF: relayNext = 1'b0;
						// Hold uses the unmasked state so an LED-only channel keeps its lamp.
						default:   relayNext = ledQ;
					endcase
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					relayQ <= RESET_OUT;
					ledQ   <= RESET_OUT;
				end else begin
					relayQ <= relayNext & relayFitted[ch];
					ledQ   <= relayNext;
				end
			end

			assign relayDrive[ch]   = relayQ;
			assign indicatorLed[ch] = ledQ;
		end
	endgenerate
endmodule

// ==== rtl/rtc_pkg.sv ====
package rtc_pkg;

	// Operating modes of one output channel.
	typedef enum logic [2:0] {
		MODE_INACTIVE = 3'h0,
		MODE_ONE_ON   = 3'h1,
		MODE_ONE_OFF  = 3'h2,
		MODE_INSIDE   = 3'h3,
		MODE_OUTSIDE  = 3'h4,
		MODE_SERIAL   = 3'h5
	} rtc_mode_type;

	// Reaction to a fault situation.
	typedef enum logic [1:0] {
		FAULT_HOLD = 2'h0,
		FAULT_ON   = 2'h1,
		FAULT_OFF  = 2'h2
	} rtc_fault_type;

	localparam int VALUE_W = 16;
	localparam int DELAY_W = 10;
	localparam int GAP_W   = 7;
	localparam int COUNT_W = 20;

	localparam logic signed [VALUE_W-1:0] THRESH_MIN = -16'sd999;
	localparam logic signed [VALUE_W-1:0] THRESH_MAX = 16'sd9999;
	localparam logic [VALUE_W-1:0]        BAND_MAX   = 16'h03E7;
	localparam logic [DELAY_W-1:0]        DELAY_MAX  = 10'h3E7;
	localparam logic [GAP_W-1:0]          GAP_MAX    = 7'h63;

	// Tenth-second ticks per unit step of a delay, and per second of frame gap timeout.
	localparam logic [COUNT_W-1:0] TENTHS_PER_SEC_STEP = 20'h0_0001;
	localparam logic [COUNT_W-1:0] TENTHS_PER_MIN_STEP = 20'h0_003C;
	localparam logic [COUNT_W-1:0] TENTHS_PER_SEC      = 20'h0_000A;

	// Tick period derived from the 40 MHz clock.
	localparam int CLK_HZ         = 40_000_000;
	localparam int TICK_PERIOD_MS = 100;
	localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;

	localparam logic RESET_OUT = 1'b0;

endpackage

// ==== rtl/rtc_tick_divider.sv ====
`timescale 1ns/1ps
// Produces a one-cycle enable every tenth of a second for the dwell timers.
module rtc_tick_divider
	import rtc_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Tick output.
	output logic      tick
);
	logic [31:0] countQ;

	always_ff @(posedge clk) begin
		if (rst) begin
			countQ <= 32'h0000_0000;
			tick   <= 1'b0;
		end else if (countQ == 32'(CYCLES - 1)) begin
			countQ <= 32'h0000_0000;
			tick   <= 1'b1;
		end else begin
			countQ <= countQ + 32'h0000_0001;
			tick   <= 1'b0;
		end
	end
endmodule

// ==== bench/rtc_relay_load.sv ====
`timescale 1ns/1ps
// Relay coils; counting contact changes makes a chattering output visible.
module rtc_relay_load #(
	parameter int N = 3
) (
	// Clock, reset and coil drive.
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] relayDrive,
	// Number of cycles in which any contact changed.
	output int                flips
);
	logic [N-1:0] coil_q;
	always_ff @(posedge clk) begin
		coil_q <= relayDrive;
		if (rst)
			flips <= 0;
		else if (coil_q != relayDrive)
			flips <= flips + 1;
	end
endmodule

// ==== bench/rtc_chk.sv ====
`timescale 1ns/1ps
// Channel 0 is checked for threshold behaviour, channel 2 as the unfitted one.
module rtc_chk
	import rtc_pkg::*;
#(
	parameter int CHANNELS = 3
) (
	// Clock and reset.
	input wire logic                        clk,
	input wire logic                        rst,
	// Measurement and settings.
	input wire logic signed [VALUE_W-1:0]   measuredValue,
	input wire logic                        measuredOutOfRange,
	input wire logic [GAP_W-1:0]            frame_gap_timeout,
	input wire logic [CHANNELS*VALUE_W-1:0] first_threshold,
	input wire logic [CHANNELS*VALUE_W-1:0] band_half_width,
	input wire logic [CHANNELS*3-1:0]       channelMode,
	input wire logic [CHANNELS*DELAY_W-1:0] turn_on_delay,
	input wire logic [CHANNELS*DELAY_W-1:0] turn_off_delay,
	input wire logic [CHANNELS*2-1:0]       fault_response,
	input wire logic [CHANNELS-1:0]         usePeak,
	input wire logic [CHANNELS-1:0]         relayFitted,
	// Outputs.
	input wire logic [CHANNELS-1:0]         relayDrive,
	input wire logic [CHANNELS-1:0]         indicatorLed,
	input wire logic                        serialFault
);
	logic signed [VALUE_W-1:0] thr;
	logic signed [VALUE_W-1:0] bw;
	logic                      base, hi, lo, mid, inact, forced;
	assign thr = first_threshold[VALUE_W-1:0];
	assign bw = band_half_width[VALUE_W-1:0];
	// Only undelayed, fault-free one-on periods have a fixed answer time.
	assign base = channelMode[2:0] == MODE_ONE_ON && !usePeak[0] && !measuredOutOfRange
		&& turn_on_delay[DELAY_W-1:0] == '0 && turn_off_delay[DELAY_W-1:0] == '0;
	assign hi = base && measuredValue > thr + bw;
	assign lo = base && measuredValue < thr - bw;
	assign mid = base && !hi && !lo;
	assign inact = channelMode[2:0] == MODE_INACTIVE && fault_response[1:0] != FAULT_ON;
	assign forced = channelMode[2:0] == MODE_INACTIVE && fault_response[1:0] == FAULT_ON;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_clear: assert property (
		$past(rst) |-> relayDrive == '0 && indicatorLed == '0 && !serialFault)
		else $error("outputs not cleared by reset");
	a_led_relay: assert property (
		relayFitted[0] && $past(relayFitted[0]) |-> relayDrive[0] == indicatorLed[0])
		else $error("lamp differs from relay");
	a_unfitted_dark: assert property (
		!relayFitted[2] && !$past(relayFitted[2]) |-> !relayDrive[2])
		else $error("unfitted relay driven");
	a_band_holds: assert property (
		mid && $past(mid) && $past(mid, 2) && $past(mid, 3) |-> $stable(indicatorLed[0]))
		else $error("output changed inside band");
	a_rise_on: assert property (hi [*4] |-> indicatorLed[0])
		else $error("no switch on above band");
	a_inact_dark: assert property (inact [*3] |-> !indicatorLed[0])
		else $error("inactive channel lit");
	a_inact_force: assert property (forced [*3] |-> indicatorLed[0])
		else $error("forced-on inactive channel dark");
	a_gap_off: assert property ((frame_gap_timeout == '0) [*4] |-> !serialFault)
		else $error("gap fault with supervision off");
endmodule
bind relay_threshold_controller rtc_chk #(.CHANNELS(CHANNELS)) chk (.*);

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
	import rtc_pkg::*;
;
	localparam int N = 3;
	logic clk = 0, rst = 1;
	logic signed [VALUE_W-1:0] measuredValue = '0, peakValue = '0;
	logic measuredOutOfRange = 0, peakOutOfRange = 0, frameReceived = 0, serialWrite = 0;
	logic [N-1:0] serialState = '0, unitMinutes = '0, usePeak = '0, relayFitted = 3'h3;
	logic [N-1:0] relayDrive, indicatorLed, st = '0;
	logic serialFault;
	logic [GAP_W-1:0] frame_gap_timeout = '0;
	// Borders stay inside the range and the two window bands stay apart.
	logic [N*VALUE_W-1:0] first_threshold = {16'h01F4, 16'h0064, 16'h0064};
	logic [N*VALUE_W-1:0] second_threshold = {16'h00C8, 32'h0000_0000};
	logic [N*VALUE_W-1:0] band_half_width = {3{16'h000A}};
	logic [N*3-1:0] channelMode = {MODE_INSIDE, MODE_ONE_OFF, MODE_ONE_ON};
	logic [N*DELAY_W-1:0] turn_on_delay = '0, turn_off_delay = '0;
	logic [N*2-1:0] fault_response = '0;
	logic [3:0] q[$];
	int flips, f, err_total = 0, n_tests = 0, cyc = 0;
	event chkEv;
	relay_threshold_controller #(.CHANNELS(N), .TICK_DIV(10)) uut (.*);
	rtc_relay_load #(.N(N)) load (.*);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hysteresis reference for the three channels; the band keeps the last state.
	function automatic logic [N-1:0] refOf(input logic signed [VALUE_W-1:0] v);
		if (v > 16'sh006E || v < 16'sh005A)
			st[1:0] = v > 16'sh006E ? 2'h1 : 2'h2;
		if (v > 16'sh00D2 && v < 16'sh01EA)
			st[2] = channelMode[8:6] == MODE_INSIDE;
		else if (v < 16'sh00BE || v > 16'sh01FE)
			st[2] = channelMode[8:6] != MODE_INSIDE;
		return st;
	endfunction
	// The live value is parked far off while peaks are compared, to catch a wrong pick.
	task automatic step(input logic signed [VALUE_W-1:0] v, input int n, input logic [3:0] e);
		measuredValue = usePeak[0] ? 16'sh1F40 : v;
		peakValue = v;
		repeat (n) @(negedge clk);
		q.push_back(e);
		->chkEv;
	endtask
	task automatic send(input logic [N-1:0] s);
		serialState = s;
		serialWrite = 1;
		frameReceived = 1;
		@(negedge clk);
		serialWrite = 0;
		frameReceived = 0;
	endtask
	always @(chkEv) begin
		check({serialFault, indicatorLed}, q[0]);
		check({1'b0, relayDrive}, {1'b0, q[0][2:0] & relayFitted});
		void'(q.pop_front());
	end
	initial begin
		logic [3:0] e;
		logic signed [VALUE_W-1:0] v;
		logic signed [VALUE_W-1:0] lv[3] = '{16'sh0096, 16'sh0064, 16'sh0032};
		void'($urandom(32'h0000_CB81));
		repeat (12) @(negedge clk);
		rst = 0;
		usePeak = 3'h7;
		for (int i = 0; i < 12; i++) begin
			v = 16'($urandom_range(700)) - 16'sh0064;
			if (i == 6)
				channelMode[8:6] = MODE_OUTSIDE;
			step(v, 4, {1'b0, refOf(v)});
		end
		usePeak = '0;
		foreach (lv[k]) step(lv[k], 6, {1'b0, refOf(lv[k])});
		$display("test levels done");
		turn_on_delay[9:0] = 10'h003;
		e = {1'b0, refOf(16'sh0096)};
		e[0] = 0;
		f = flips;
		step(16'sh0096, 15, e);
		step(16'sh0032, 4, {1'b0, refOf(16'sh0032)});
		check(4'(flips - f), 4'h2);
		step(16'sh0096, 45, {1'b0, refOf(16'sh0096)});
		unitMinutes[0] = 1;
		turn_off_delay[9:0] = 10'h001;
		e = {1'b0, refOf(16'sh0032)};
		e[0] = 1;
		step(16'sh0032, 400, e);
		step(16'sh0032, 300, {1'b0, refOf(16'sh0032)});
		$display("test delays done");
		fault_response = {FAULT_OFF, FAULT_HOLD, FAULT_ON};
		measuredOutOfRange = 1;
		step(16'sh0032, 4, 4'h3);
		measuredOutOfRange = 0;
		channelMode[2:0] = MODE_INACTIVE;
		step(16'sh0032, 4, 4'h7);
		fault_response[1:0] = FAULT_HOLD;
		step(16'sh0032, 4, 4'h6);
		$display("test faults done");
		channelMode[5:3] = MODE_SERIAL;
		fault_response[3:2] = FAULT_OFF;
		frame_gap_timeout = 7'h01;
		send(3'h7);
		step(16'sh0032, 4, 4'h6);
		send(3'h5);
		step(16'sh0032, 4, 4'h4);
		send(3'h2);
		step(16'sh0032, 90, 4'h6);
		step(16'sh0032, 110, 4'hC);
		frame_gap_timeout = '0;
		step(16'sh0032, 200, 4'h6);
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
		step(16'sh0032, 6, 4'h4);
		$display("test serial done");
		summarize();
	end
endmodule
